// File: core/opqs_status.sv
`timescale 1ns/100ps
`default_nettype none
module opqs_status (
   input  wire logic                        sys_clk_in,
   input  wire logic                        arst_n_in,
   input  wire logic                        iq_cal_busy_in,
   input  wire logic                        sweep_busy_in,
   input  wire logic                        bit_error_test_busy_in,
   input  wire logic                        trigger_wait_in,
   input  wire logic                        dc_fm_phase_zero_cal_in,
   input  wire logic                        waveform_playback_in,
   input  wire logic                        presweep_calc_in,
   input  wire logic                        channel_sync_in,
   input  wire logic                        power_summary_in,
   input  wire logic                        oven_cold_in,
   input  wire logic                        frequency_summary_in,
   input  wire logic                        modulation_summary_in,
   input  wire logic                        calibration_summary_in,
   input  wire logic                        self_test_fail_in,
   input  wire logic                        bit_error_test_group_in,
   input  wire logic                        reg_wr_in,
   input  wire logic                        reg_rd_in,
   input  wire logic [3:0]                  reg_sel_in,
   input  wire logic [opqs_pkg::REG_W-1:0]  reg_wdata_in,
   input  wire logic                        clear_status_in,
   output logic      [opqs_pkg::REG_W-1:0]  reg_rdata_out,
   output logic                             reg_rvalid_out,
   output logic                             oper_summary_out,
   output logic                             ques_summary_out
);
   import opqs_pkg::*;

   logic [REG_W-1:0] oper_cond;
   logic [REG_W-1:0] oper_prev;
   logic [REG_W-1:0] oper_fall;
   logic [REG_W-1:0] oper_rise;
   logic [REG_W-1:0] oper_event;
   logic [REG_W-1:0] oper_enable;
   logic [REG_W-1:0] ques_cond;
   logic [REG_W-1:0] ques_prev;
   logic [REG_W-1:0] ques_fall;
   logic [REG_W-1:0] ques_rise;
   logic [REG_W-1:0] ques_event;
   logic [REG_W-1:0] ques_enable;
   logic             self_test_latch;
   logic [REG_W-1:0] oper_raw;
   logic [REG_W-1:0] ques_raw;
   logic [REG_W-1:0] next_oper_event;
   logic [REG_W-1:0] next_ques_event;
   logic [REG_W-1:0] next_rdata;

   function automatic logic [REG_W-1:0] edges(input logic [REG_W-1:0] cur,
                                             input logic [REG_W-1:0] prev,
                                             input logic [REG_W-1:0] rise,
                                             input logic [REG_W-1:0] fall);
      edges = (cur & ~prev & rise) | (~cur & prev & fall);
   endfunction

   function automatic logic [REG_W-1:0] next_event(input logic [REG_W-1:0] ev,
                                                  input logic [REG_W-1:0] hits,
                                                  input logic             clr);
      next_event = (clr ? '0 : ev) | hits;
   endfunction

   always_comb begin
      oper_raw     = '0;
      oper_raw[0]  = iq_cal_busy_in;
      oper_raw[3]  = sweep_busy_in;
      oper_raw[4]  = bit_error_test_busy_in;
      oper_raw[5]  = trigger_wait_in;
      oper_raw[9]  = dc_fm_phase_zero_cal_in;
      oper_raw[10] = waveform_playback_in;
      oper_raw[11] = presweep_calc_in;
      oper_raw[12] = channel_sync_in;
      ques_raw     = '0;
      ques_raw[3]  = power_summary_in;
      ques_raw[4]  = oven_cold_in;
      ques_raw[5]  = frequency_summary_in;
      ques_raw[7]  = modulation_summary_in;
      ques_raw[8]  = calibration_summary_in;
      ques_raw[9]  = self_test_latch;
      ques_raw[12] = bit_error_test_group_in;
   end

   // Power-up self-test failure sticks until reset; clear-status leaves it
   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         self_test_latch <= 1'b0;
      end else if (self_test_fail_in) begin
         self_test_latch <= 1'b1;
      end
   end

   // Condition registers sample live status; host writes never reach them
   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         oper_cond <= '0;
         ques_cond <= '0;
         oper_prev <= '0;
         ques_prev <= '0;
      end else begin
         oper_cond <= oper_raw & OPER_USED;
         ques_cond <= ques_raw & QUES_USED;
         oper_prev <= oper_cond;
         ques_prev <= ques_cond;
      end
   end

   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         oper_fall   <= FALL_RESET;
         oper_rise   <= RISE_RESET;
         oper_enable <= ENABLE_RESET;
         ques_fall   <= FALL_RESET;
         ques_rise   <= RISE_RESET;
         ques_enable <= ENABLE_RESET;
      end else if (reg_wr_in) begin
         case (reg_sel_in)
            SEL_OPER_FALL: begin
               oper_fall <= reg_wdata_in;
            end
            SEL_OPER_RISE: begin
               oper_rise <= reg_wdata_in;
            end
            SEL_OPER_ENABLE: begin
               oper_enable <= reg_wdata_in;
            end
            SEL_QUES_FALL: begin
               ques_fall <= reg_wdata_in;
            end
            SEL_QUES_RISE: begin
               ques_rise <= reg_wdata_in;
            end
            SEL_QUES_ENABLE: begin
               ques_enable <= reg_wdata_in;
            end
            default: begin
            end
         endcase
      end
   end

   always_comb begin
      next_oper_event = next_event(oper_event,
                                   edges(oper_cond, oper_prev, oper_rise, oper_fall),
                                   clear_status_in ||
                                   (reg_rd_in && reg_sel_in == SEL_OPER_EVENT));
      next_ques_event = next_event(ques_event,
                                   edges(ques_cond, ques_prev, ques_rise, ques_fall),
                                   clear_status_in ||
                                   (reg_rd_in && reg_sel_in == SEL_QUES_EVENT));
   end

   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         oper_event <= '0;
         ques_event <= '0;
      end else begin
         oper_event <= next_oper_event;
         ques_event <= next_ques_event;
      end
   end

   // Read data is the plain bit pattern, i.e. the binary-weighted sum
   always_comb begin
      case (reg_sel_in)
         SEL_OPER_COND:   next_rdata = oper_cond;
         SEL_OPER_FALL:   next_rdata = oper_fall;
         SEL_OPER_RISE:   next_rdata = oper_rise;
         SEL_OPER_EVENT:  next_rdata = oper_event;
         SEL_OPER_ENABLE: next_rdata = oper_enable;
         SEL_QUES_COND:   next_rdata = ques_cond;
         SEL_QUES_FALL:   next_rdata = ques_fall;
         SEL_QUES_RISE:   next_rdata = ques_rise;
         SEL_QUES_EVENT:  next_rdata = ques_event;
         SEL_QUES_ENABLE: next_rdata = ques_enable;
         default:         next_rdata = '0;
      endcase
   end

   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         reg_rdata_out  <= '0;
         reg_rvalid_out <= 1'b0;
      end else begin
         reg_rvalid_out <= reg_rd_in;
         if (reg_rd_in) begin
            reg_rdata_out <= next_rdata;
         end
      end
   end

   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         oper_summary_out <= 1'b0;
         ques_summary_out <= 1'b0;
      end else begin
         oper_summary_out <= |(next_oper_event & oper_enable);
         ques_summary_out <= |(next_ques_event & ques_enable);
      end
   end
endmodule
`default_nettype wire

// File: core/opqs_pkg.sv
// Overview of operation
// - Operation bit 0 high during I/Q calibration
// - Bits 3,4,5: sweep, error test, trigger wait
// - Bits 9-12: zero cal, playback, presweep, sync
// - Unused operation bits read zero in condition and event registers
// - Condition registers track inputs, ignore writes
// - Query returns binary-weighted bit sum
// - Falling filter picks 1-0, rising picks 0-1
// - Selected transition latches sticky event bit
// - Event read returns value and clears it
// - Operation summary drives status byte bit 7
// - Enable read returns last written mask
// - Questionable group complete, summary bit 3
// - Questionable bit 3 follows power summary
// - Questionable bit 4 high while oven cold
// - Questionable bit 5 follows frequency summary
// - Questionable bit 7 follows modulation summary
// - Questionable bit 8 follows calibration summary
// - Self-test fail bit cleared only by reset
// - Questionable bit 12 follows error-test summary
// - Unused questionable bits read zero in condition and event registers
// - Events held until read or clear-status
// - Summary is OR of event AND enable
package opqs_pkg;
   localparam int unsigned REG_W = 16;
   localparam logic [3:0] SEL_OPER_COND = 4'h0;
   localparam logic [3:0] SEL_OPER_FALL = 4'h1;
   localparam logic [3:0] SEL_OPER_RISE = 4'h2;
   localparam logic [3:0] SEL_OPER_EVENT = 4'h3;
   localparam logic [3:0] SEL_OPER_ENABLE = 4'h4;
   localparam logic [3:0] SEL_QUES_COND = 4'h8;
   localparam logic [3:0] SEL_QUES_FALL = 4'h9;
   localparam logic [3:0] SEL_QUES_RISE = 4'ha;
   localparam logic [3:0] SEL_QUES_EVENT = 4'hb;
   localparam logic [3:0] SEL_QUES_ENABLE = 4'hc;
   localparam logic [15:0] FALL_RESET = 16'h0000;
   localparam logic [15:0] RISE_RESET = 16'hffff;
   localparam logic [15:0] ENABLE_RESET = 16'h0000;
   localparam logic [15:0] OPER_USED = 16'h1e39;
   localparam logic [15:0] QUES_USED = 16'h13b8;
endpackage

// File: tb/opqs_status_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module opqs_status_monitor import opqs_pkg::*; (
   input wire logic                       sys_clk_in,
   input wire logic                       arst_n_in,
   input wire logic                       iq_cal_busy_in,
   input wire logic                       self_test_fail_in,
   input wire logic                       reg_wr_in,
   input wire logic                       reg_rd_in,
   input wire logic [3:0]                 reg_sel_in,
   input wire logic                       clear_status_in,
   input wire logic [opqs_pkg::REG_W-1:0] reg_rdata_out,
   input wire logic                       reg_rvalid_out,
   input wire logic                       oper_summary_out,
   input wire logic                       ques_summary_out
);
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!arst_n_in);
   a_read_answer: assert property (reg_rd_in |=> reg_rvalid_out)
      else $error("read not answered after one cycle");
   a_rvalid_pulse: assert property (!reg_rd_in |=> !reg_rvalid_out)
      else $error("read valid without a read");
   a_oper_unused: assert property (reg_rd_in && reg_sel_in == SEL_OPER_COND
      |=> (reg_rdata_out & ~OPER_USED) == 16'h0000) else $error("unused operation bit set");
   a_ques_unused: assert property (reg_rd_in && reg_sel_in == SEL_QUES_COND
      |=> (reg_rdata_out & ~QUES_USED) == 16'h0000) else $error("unused questionable bit set");
   a_iq_cal_bit: assert property ($past(arst_n_in) && reg_rd_in && reg_sel_in == SEL_OPER_COND
      |=> reg_rdata_out[0] == $past(iq_cal_busy_in, 2)) else $error("calibration bit wrong");
   a_self_test_held: assert property ($past(self_test_fail_in, 2) && $past(arst_n_in, 2)
      && reg_rd_in && reg_sel_in == SEL_QUES_COND |=> reg_rdata_out[9])
      else $error("self-test bit not held");
   a_oper_sticky: assert property ($fell(oper_summary_out) |-> $past(reg_rd_in
      || clear_status_in || reg_wr_in) || $past(reg_rd_in || clear_status_in || reg_wr_in, 2))
      else $error("operation summary dropped without cause");
   a_ques_sticky: assert property ($fell(ques_summary_out) |-> $past(reg_rd_in
      || clear_status_in || reg_wr_in) || $past(reg_rd_in || clear_status_in || reg_wr_in, 2))
      else $error("questionable summary dropped without cause");
   c_oper_sum: cover property (oper_summary_out);
   c_ques_sum: cover property (ques_summary_out);
   c_clear: cover property (clear_status_in);
endmodule
`default_nettype wire

// File: tb/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   import opqs_pkg::*;
   logic        sys_clk_in = 1'b0;
   logic        arst_n_in  = 1'b0;
   logic [14:0] st         = 15'h0000;
   logic        wr = 1'b0, rd = 1'b0, clr = 1'b0;
   logic [3:0]  sel        = 4'h0;
   logic [15:0] wd         = 16'h0000;
   logic [15:0] rdata;
   logic        rvalid, osum, qsum;
   int          err_total  = 0;
   int          checked    = 0;
   int          pos [14]   = '{0, 3, 4, 5, 9, 10, 11, 12, 3, 4, 5, 7, 8, 12};
   always #4 sys_clk_in = ~sys_clk_in;
   opqs_status u_opqs_status (.sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in),
      .iq_cal_busy_in(st[0]), .sweep_busy_in(st[1]), .bit_error_test_busy_in(st[2]),
      .trigger_wait_in(st[3]), .dc_fm_phase_zero_cal_in(st[4]), .waveform_playback_in(st[5]),
      .presweep_calc_in(st[6]), .channel_sync_in(st[7]), .power_summary_in(st[8]),
      .oven_cold_in(st[9]), .frequency_summary_in(st[10]), .modulation_summary_in(st[11]),
      .calibration_summary_in(st[12]), .bit_error_test_group_in(st[13]),
      .self_test_fail_in(st[14]), .reg_wr_in(wr), .reg_rd_in(rd), .reg_sel_in(sel),
      .reg_wdata_in(wd), .clear_status_in(clr), .reg_rdata_out(rdata),
      .reg_rvalid_out(rvalid), .oper_summary_out(osum), .ques_summary_out(qsum));
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk_in);
      #1;
   endtask
   task automatic wreg(input logic [3:0] s, input logic [15:0] d);
      sel = s;
      wd = d;
      wr = 1'b1;
      tick(1);
      wr = 1'b0;
      tick(1);
   endtask
   task automatic rreg(input logic [3:0] s, input logic [15:0] exp);
      sel = s;
      rd = 1'b1;
      tick(1);
      rd = 1'b0;
      chk({15'h0000, rvalid}, 16'h0001);
      chk(rdata, exp);
      tick(1);
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      #40000;
      err_total++;
      wrap_up();
   end
   initial begin
      tick(2);
      arst_n_in = 1'b1;
      tick(1);
      for (int s = 0; s < 16; s++) rreg(s[3:0], (s == 2 || s == 10) ? 16'hffff : 16'h0000);
      $display("test reset_values done");
      for (int i = 0; i < 14; i++) begin
         st[13:0] = 14'h0001 << i;
         tick(2);
         rreg(i < 8 ? SEL_OPER_COND : SEL_QUES_COND, 16'h0001 << pos[i]);
      end
      st[13:0] = 14'h3fff;
      tick(2);
      wreg(SEL_OPER_COND, 16'hffff);
      rreg(SEL_OPER_COND, 16'h1e39);
      rreg(SEL_QUES_COND, 16'h11b8);
      st = 15'h0000;
      rreg(SEL_OPER_EVENT, 16'h1e39);
      rreg(SEL_OPER_EVENT, 16'h0000);
      st[14] = 1'b1;
      tick(1);
      st[14] = 1'b0;
      clr = 1'b1;
      tick(3);
      clr = 1'b0;
      rreg(SEL_QUES_COND, 16'h0200);
      rreg(SEL_QUES_EVENT, 16'h0000);
      $display("test conditions_events done");
      wreg(SEL_OPER_RISE, 16'h0000);
      wreg(SEL_OPER_FALL, 16'h0008);
      wreg(SEL_OPER_ENABLE, 16'h0008);
      rreg(SEL_OPER_ENABLE, 16'h0008);
      st[1] = 1'b1;
      tick(3);
      chk({15'h0000, osum}, 16'h0000);
      st[1] = 1'b0;
      tick(3);
      chk({15'h0000, osum}, 16'h0001);
      clr = 1'b1;
      tick(1);
      clr = 1'b0;
      tick(1);
      chk({15'h0000, osum}, 16'h0000);
      $display("test operation_summary done");
      wreg(SEL_QUES_ENABLE, 16'h0010);
      st[9] = 1'b1;
      tick(3);
      chk({15'h0000, qsum}, 16'h0001);
      rreg(SEL_QUES_EVENT, 16'h0010);
      chk({15'h0000, qsum}, 16'h0000);
      st[9] = 1'b0;
      tick(2);
      st[9] = 1'b1;
      tick(1);
      rreg(SEL_QUES_EVENT, 16'h0000);
      rreg(SEL_QUES_EVENT, 16'h0010);
      $display("test questionable_summary done");
      wrap_up();
   end
endmodule
bind opqs_status opqs_status_monitor u_opqs_status_monitor (.sys_clk_in(sys_clk_in),
   .arst_n_in(arst_n_in), .iq_cal_busy_in(iq_cal_busy_in), .reg_wr_in(reg_wr_in),
   .self_test_fail_in(self_test_fail_in), .reg_rd_in(reg_rd_in), .reg_sel_in(reg_sel_in),
   .clear_status_in(clear_status_in), .reg_rdata_out(reg_rdata_out),
   .reg_rvalid_out(reg_rvalid_out), .oper_summary_out(oper_summary_out),
   .ques_summary_out(ques_summary_out));
`default_nettype wire
